// ===== core/sss_consts.svh
// Constants of the select-gated serial slave: offsets, fields, modes, resets
`ifndef SSS_CONSTS_SVH
`define SSS_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define SSS_OFF_CTRL 8'h00
`define SSS_OFF_DATA 8'h04
`define SSS_OFF_STAT 8'h08
`define SSS_OFF_MASK 8'h0C
`define SSS_OFF_INFO 8'h10

// ==========================================================
// Control register fields
`define SSS_CTRL_EN 0
`define SSS_CTRL_MODE_LO 1
`define SSS_CTRL_MODE_HI 4
`define SSS_CTRL_IDLE_HI 5
`define SSS_CTRL_CKE 6
`define SSS_CTRL_RST 8'h00

// ==========================================================
// Port mode field encodings
`define SSS_MODE_SLV_SEL 4'h4
`define SSS_MODE_SLV_NOSEL 4'h5

// ==========================================================
// Status and mask fields
`define SSS_ST_DONE 0
`define SSS_ST_SYNC 1
`define SSS_ST_CFG 2
`define SSS_ST_W 3
`define SSS_ST_RST 3'h0

// ==========================================================
// Bit counter and info register fields
`define SSS_CNT_LAST 3'h7
`define SSS_CNT_ZERO 3'h0
`define SSS_INFO_LOADED 3
`define SSS_INFO_SEL 4

// ==========================================================
// Reset values of datapath registers; the select pin idles high
`define SSS_PINS_RST 3'h4
`define SSS_WORD_RST 32'h0000_0000
`define SSS_BYTE_RST 8'h00

`endif

// ===== core/sss_pkg.sv
// Types shared by the select-gated serial slave
package sss_pkg;
   typedef logic [7:0] sss_adr_t;
   typedef logic [31:0] sss_word_t;
   typedef logic [3:0] sss_sel_t;
   typedef logic [7:0] sss_byte_t;
   typedef logic [3:0] sss_mode_t;
   typedef logic [2:0] sss_cnt_t;
endpackage : sss_pkg

// ===== core/sss_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module sss_sync #(
   parameter int W = 3
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   input wire logic [W-1:0] rst_val_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // ==========================================================
   // Per-bit chain; a change counts once stages two and three agree
   for (genvar i = 0; i < W; i++)
   begin : g_bit
      always_ff @(posedge clk_i)
      begin
         s1_q[i] <= d_i[i];
         s2_q[i] <= s1_q[i];
         s3_q[i] <= s2_q[i];
         if (rst_i)
         begin
            q_o[i] <= rst_val_i[i];
         end
         else if (s2_q[i] == s3_q[i])
         begin
            q_o[i] <= s3_q[i];
         end
      end
   end
endmodule : sss_sync

// ===== core/sss_core.sv
// Select-gated serial slave port with classic Wishbone register access
//
// How it works
// - Select honoured only in select-enabled slave mode
// - Select low: normal slave, shifts on external clock
// - Select high: port held reset, data output released
// - Slave with edge select needs select control
// - Port reset clears bit counter to zero
// - After reset, transmit only after buffer write
// - Shifting continues during device sleep
// - Eight bits set flag; enabled flag wakes device
`timescale 1ns/1ps
`include "sss_consts.svh"
module sss_core (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire sss_pkg::sss_adr_t wb_adr_i,
   input wire sss_pkg::sss_sel_t wb_sel_i,
   input wire sss_pkg::sss_word_t wb_dat_i,
   output sss_pkg::sss_word_t wb_dat_o,
   output logic wb_ack_o,
   input wire logic sck_i,
   input wire logic sdi_i,
   input wire logic sel_n_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   input wire logic sleep_i,
   output logic irq_o,
   output logic wake_o
);
   import sss_pkg::*;

   // ==========================================================
   // Declarations
   sss_byte_t ctrl_q;
   sss_byte_t shift_q;
   sss_byte_t rxbuf_q;
   sss_cnt_t cnt_q;
   logic [`SSS_ST_W-1:0] stat_q;
   logic [`SSS_ST_W-1:0] stat_d;
   logic [`SSS_ST_W-1:0] mask_q;
   logic [`SSS_ST_W-1:0] ev;
   logic loaded_q;
   logic active_p_q;
   logic tx_bit_q;
   logic ack_q;
   logic irq_q;
   logic wake_q;
   logic oe_q;
   sss_word_t rdat_q;
   logic [2:0] pins_f;
   logic sck_f;
   logic sdi_f;
   logic sel_f;
   logic sck_p_q;
   logic sel_p_q;
   sss_mode_t mode;
   logic en;
   logic idle_hi;
   logic cke;
   logic sel_mode;
   logic slave;
   logic cfg_err;
   logic active;
   logic port_rst;
   logic rise;
   logic fall;
   logic lead;
   logic trail;
   logic samp;
   logic shf;
   logic req;
   logic wr;
   logic rd;
   logic wr_data;
   logic rd_stat;
   logic byte_done;

   // Address decode, shared by read and write paths
   function automatic logic sss_hit(input sss_adr_t a, input sss_adr_t off);
      return a == off;
   endfunction : sss_hit

   // ==========================================================
   // Pin synchronisers; select idles high so reset value is one
   sss_sync #(
      .W(3)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({sel_n_i, sdi_i, sck_i}),
      .rst_val_i(`SSS_PINS_RST),
      .q_o(pins_f)
   );
   assign sck_f = pins_f[0];
   assign sdi_f = pins_f[1];
   assign sel_f = pins_f[2];

   // ==========================================================
   // Mode decode
   assign mode = ctrl_q[`SSS_CTRL_MODE_HI:`SSS_CTRL_MODE_LO];
   assign en = ctrl_q[`SSS_CTRL_EN];
   assign idle_hi = ctrl_q[`SSS_CTRL_IDLE_HI];
   assign cke = ctrl_q[`SSS_CTRL_CKE];
   assign sel_mode = (mode == `SSS_MODE_SLV_SEL);
   assign slave = sel_mode || (mode == `SSS_MODE_SLV_NOSEL);
   // Edge-select slave without select control is refused outright
   assign cfg_err = (mode == `SSS_MODE_SLV_NOSEL) && cke;
   // Select only gates the port in select mode; low select runs the slave
   assign active = en && slave && !cfg_err && !(sel_mode && sel_f);
   assign port_rst = !active;

   // ==========================================================
   // Link clock edges, seen by the system clock
   assign rise = sck_f && !sck_p_q;
   assign fall = !sck_f && sck_p_q;
   assign lead = idle_hi ? fall : rise;
   assign trail = idle_hi ? rise : fall;
   assign samp = cke ? lead : trail;
   assign shf = cke ? trail : lead;

   // ==========================================================
   // Bus strobes
   assign req = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr = req && wb_we_i && wb_sel_i[0];
   assign rd = req && !wb_we_i;
   assign wr_data = wr && sss_hit(wb_adr_i, `SSS_OFF_DATA);
   assign rd_stat = rd && sss_hit(wb_adr_i, `SSS_OFF_STAT);
   assign byte_done = active && samp && !wr_data && (cnt_q == `SSS_CNT_LAST);

   // Previous filtered link levels for edge finding
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sck_p_q <= 1'b0;
         sel_p_q <= 1'b1;
      end
      else
      begin
         sck_p_q <= sck_f;
         sel_p_q <= sel_f;
      end
   end

   // ==========================================================
   // Wishbone slave: one wait state, ack for exactly one cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_q <= 1'b0;
         rdat_q <= `SSS_WORD_RST;
      end
      else
      begin
         ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
         if (rd)
         begin
            // Unmapped offsets read as zero and are still acknowledged
            rdat_q <= `SSS_WORD_RST;
            if (sss_hit(wb_adr_i, `SSS_OFF_CTRL))
               rdat_q[7:0] <= ctrl_q;
            if (sss_hit(wb_adr_i, `SSS_OFF_DATA))
               rdat_q[7:0] <= rxbuf_q;
            if (sss_hit(wb_adr_i, `SSS_OFF_STAT))
               rdat_q[`SSS_ST_W-1:0] <= stat_q;
            if (sss_hit(wb_adr_i, `SSS_OFF_MASK))
               rdat_q[`SSS_ST_W-1:0] <= mask_q;
            if (sss_hit(wb_adr_i, `SSS_OFF_INFO))
               rdat_q[7:0] <= {3'h0, sel_f, loaded_q, cnt_q};
         end
      end
   end

   // Control and mask registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_q <= `SSS_CTRL_RST;
         mask_q <= `SSS_ST_RST;
      end
      else
      begin
         if (wr && sss_hit(wb_adr_i, `SSS_OFF_CTRL))
            ctrl_q <= wb_dat_i[7:0];
         if (wr && sss_hit(wb_adr_i, `SSS_OFF_MASK))
            mask_q <= wb_dat_i[`SSS_ST_W-1:0];
      end
   end

   // ==========================================================
   // Shift engine. The system clock keeps running in sleep, so the
   // engine keeps sampling the link clock; only the core sleeps.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         shift_q <= `SSS_BYTE_RST;
         rxbuf_q <= `SSS_BYTE_RST;
         cnt_q <= `SSS_CNT_ZERO;
         tx_bit_q <= 1'b0;
      end
      else
      begin
         if (port_rst)
         begin
            // Counter only; the reload flag has its own process below
            cnt_q <= `SSS_CNT_ZERO;
         end
         if (wr_data)
         begin
            // Buffer write reloads the shift register and re-arms output
            shift_q <= wb_dat_i[7:0];
            tx_bit_q <= wb_dat_i[7];
         end
         else if (active && samp)
         begin
            shift_q <= {shift_q[6:0], sdi_f};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == `SSS_CNT_LAST)
               rxbuf_q <= {shift_q[6:0], sdi_f};
         end
         else if (active && shf)
         begin
            tx_bit_q <= shift_q[7];
         end
      end
   end

   // Reload flag: cleared on entry into port reset, not while it lasts,
   // so a buffer write made with select still high arms the next frame
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         loaded_q <= 1'b0;
         active_p_q <= 1'b0;
      end
      else
      begin
         active_p_q <= active;
         if (wr_data)
            loaded_q <= 1'b1;
         else if (active_p_q && !active)
            loaded_q <= 1'b0;
      end
   end

   // Output driver: released while held in reset or not reloaded
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         oe_q <= 1'b0;
      else
         oe_q <= active && (loaded_q || wr_data);
   end

   // ==========================================================
   // Sticky status; an event in the clearing read's cycle survives
   assign ev[`SSS_ST_DONE] = byte_done;
   assign ev[`SSS_ST_SYNC] = en && sel_mode && sel_f && !sel_p_q;
   assign ev[`SSS_ST_CFG] = en && cfg_err;
   assign stat_d = (rd_stat ? `SSS_ST_RST : stat_q) | ev;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         stat_q <= `SSS_ST_RST;
      else
         stat_q <= stat_d;
   end

   // Interrupt and wake, aligned with the status update
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_q <= 1'b0;
         wake_q <= 1'b0;
      end
      else
      begin
         irq_q <= |(stat_d & mask_q);
         wake_q <= sleep_i && stat_d[`SSS_ST_DONE] && mask_q[`SSS_ST_DONE];
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign sdo_o = tx_bit_q;
   assign sdo_oe_o = oe_q;
   assign irq_o = irq_q;
   assign wake_o = wake_q;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   select_ignore_a:
      assert property (en && mode == `SSS_MODE_SLV_NOSEL && !cke && sel_f && loaded_q
         |=> sdo_oe_o) else $error("select gated a non-select mode");
   shift_count_a:
      assert property (active && samp && !wr_data && cnt_q != `SSS_CNT_LAST
         |=> cnt_q == $past(cnt_q) + 3'h1) else $error("bit not counted");
   sdo_release_a:
      assert property (en && sel_mode && sel_f
         |=> !sdo_oe_o) else $error("output driven with select high");
   cfg_refuse_a:
      assert property (en && cfg_err
         |=> stat_q[`SSS_ST_CFG] && !sdo_oe_o) else $error("illegal mode not refused");
   cnt_clear_a:
      assert property (port_rst && !wr_data
         |=> cnt_q == `SSS_CNT_ZERO) else $error("counter kept on reset");
   reload_gate_a:
      assert property (active_p_q && !active && !wr_data
         |=> !loaded_q && !sdo_oe_o) else $error("reload flag kept over reset");
   oe_gate_a:
      assert property (!loaded_q && !wr_data
         |=> !sdo_oe_o) else $error("output before reload");
   sleep_shift_a:
      assert property (sleep_i && active && samp && !wr_data
         |=> shift_q[0] == $past(sdi_f)) else $error("shift stalled in sleep");
   done_flag_a:
      assert property (byte_done
         |=> stat_q[`SSS_ST_DONE]) else $error("byte done not flagged");
   done_wake_a:
      assert property (byte_done && sleep_i && mask_q[`SSS_ST_DONE]
         |=> stat_q[`SSS_ST_DONE] && wake_o && irq_o) else $error("no flag or wake");
   stat_clear_a:
      assert property (rd_stat && !ev[`SSS_ST_DONE]
         |=> !stat_q[`SSS_ST_DONE]) else $error("status read did not clear");
   irq_level_a:
      assert property (irq_o == |(stat_q & $past(mask_q)))
         else $error("interrupt level wrong");
   wake_sleep_a:
      assert property (!sleep_i
         |=> !wake_o) else $error("wake while awake");
   ack_pulse_a:
      assert property (wb_ack_o |=> !wb_ack_o)
         else $error("ack held two cycles");
   ack_answer_a:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
         |=> wb_ack_o) else $error("request not acknowledged");

   byte_cov_c: cover property (byte_done);
   sync_cov_c: cover property (ev[`SSS_ST_SYNC] ##[1:300] byte_done);
   wake_cov_c: cover property (sleep_i && wake_o);
   reload_cov_c: cover property (wr_data && !active ##[1:300] active && sdo_oe_o);
endmodule : sss_core

// ===== verif/sss_master_model.sv
// Behavioural serial master that drives the select-gated slave
`timescale 1ns/1ps
module sss_master_model (
   input wire logic miso_i,
   input wire logic miso_oe_i,
   output logic sck_o,
   output logic mosi_o,
   output logic sel_n_o
);
   // ==========================================
   // Idle: clock stands still low, select high
   initial
   begin
      sck_o = 1'b0;
      mosi_o = 1'b0;
      sel_n_o = 1'b1;
   end

   // ==========================================
   // n bits MSB first at 160 ns; slave output is read on the rise
   task automatic xfer(input logic [7:0] tx, input int n, input bit rel,
                       output logic [7:0] rx);
      rx = 8'h00;
      #83;
      sel_n_o = 1'b0;
      #80;
      for (int i = 0; i < n; i++)
      begin
         mosi_o = tx[7-i];
         #80 sck_o = 1'b1;
         rx = {rx[6:0], miso_oe_i ? miso_i : ~miso_i}; // Released line reads inverted
         #80 sck_o = 1'b0;
      end
      #80;
      // Toggle so a stale data level is never mistaken for a bit
      mosi_o = ~mosi_o;
      if (rel)
         sel_n_o = 1'b1;
   endtask : xfer
endmodule : sss_master_model

// ===== verif/spi_slave_select_sleep_test.sv
// Self-checking bench for the select-gated serial slave
`timescale 1ns/1ps
`include "sss_consts.svh"
module spi_slave_select_sleep_test;
   import sss_pkg::*;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sleep_i;
   logic sck_i, sdi_i, sel_n_i, sdo_o, sdo_oe_o, irq_o, wake_o;
   sss_adr_t wb_adr_i;
   sss_sel_t wb_sel_i;
   sss_word_t wb_dat_i, wb_dat_o, q;
   sss_byte_t tx, rx, got;
   sss_byte_t rx_q[$];
   logic [31:0] seed = 32'h0000_129E;
   int err_count = 0;
   int check_count = 0;

   sss_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sck_i(sck_i), .sdi_i(sdi_i),
      .sel_n_i(sel_n_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .sleep_i(sleep_i),
      .irq_o(irq_o), .wake_o(wake_o));
   sss_master_model m (.miso_i(sdo_o), .miso_oe_i(sdo_oe_o), .sck_o(sck_i),
      .mosi_o(sdi_i), .sel_n_o(sel_n_i));

   // ==========================================
   // Clock and helpers
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   function automatic sss_byte_t rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Classic cycle: hold until ack is sampled, then drop for one cycle
   task automatic wb(input logic we, input sss_adr_t a, input sss_word_t d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 40);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n == 40)
      begin
         chk("ack wait", 1, 0);
         results();
      end
      @(posedge clk_i);
   endtask : wb

   task automatic rd(input sss_adr_t a, input logic [31:0] e, input logic [31:0] mk,
                     input string nm);
      wb(1'b0, a, 32'h0);
      chk(nm, e, q & mk);
   endtask : rd

   // ==========================================
   // Main sequence
   initial
   begin
      rst_i = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_dat_i = 32'h0;
      wb_sel_i = 4'hF;
      sleep_i = 1'b0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("oe reset", 0, sdo_oe_o);
      rd(`SSS_OFF_CTRL, 0, 32'hFFFFFFFF, "ctrl");
      rd(`SSS_OFF_STAT, 0, 32'h5, "stat");
      rd(8'h3C, 0, 32'hFFFFFFFF, "unmapped");
      $display("test reset done");
      // Back-to-back bytes, the last one asleep
      wb(1'b1, `SSS_OFF_MASK, 32'h1);
      wb(1'b1, `SSS_OFF_CTRL, 32'h49);
      for (int k = 0; k < 3; k++)
      begin
         sleep_i <= (k == 2);
         tx = rnd();
         rx = rnd();
         rx_q.push_back(rx);
         wb(1'b1, `SSS_OFF_DATA, {24'h0, tx});
         repeat (2) @(posedge clk_i);
         chk("oe armed", 0, sdo_oe_o);
         rd(`SSS_OFF_INFO, 32'h18, 32'h18, "info armed");
         m.xfer(rx, 8, 1'b1, got);
         chk("master rx", tx, got);
         repeat (6) @(posedge clk_i);
         chk("irq", 1, irq_o);
         chk("wake", k == 2, wake_o);
         chk("oe idle", 0, sdo_oe_o);
         rd(`SSS_OFF_DATA, rx_q.pop_front(), 32'hFF, "slave rx");
         rd(`SSS_OFF_STAT, 1, 32'h1, "done");
         chk("irq clr", 0, irq_o);
      end
      sleep_i <= 1'b0;
      $display("test bytes done");
      // Partial byte cut off by select, then by disabling
      wb(1'b1, `SSS_OFF_DATA, {24'h0, rnd()});
      m.xfer(rnd(), 4, 1'b0, got);
      repeat (6) @(posedge clk_i);
      rd(`SSS_OFF_INFO, 32'h0C, 32'h1F, "info mid");
      m.xfer(8'h00, 0, 1'b1, got);
      repeat (6) @(posedge clk_i);
      rd(`SSS_OFF_INFO, 32'h10, 32'h1F, "info sel");
      chk("oe sel", 0, sdo_oe_o);
      wb(1'b1, `SSS_OFF_DATA, {24'h0, tx});
      m.xfer(tx, 3, 1'b0, got);
      @(posedge clk_i);
      wb(1'b1, `SSS_OFF_CTRL, 32'h0);
      rd(`SSS_OFF_INFO, 0, 32'hF, "info off");
      m.xfer(tx, 0, 1'b1, got);
      @(posedge clk_i);
      $display("test partial done");
      // Select ignored outside mode 0100; illegal edge select flagged
      wb(1'b1, `SSS_OFF_CTRL, 32'h0B);
      wb(1'b1, `SSS_OFF_DATA, {24'h0, tx});
      repeat (2) @(posedge clk_i);
      chk("oe nosel", 1, sdo_oe_o);
      wb(1'b1, `SSS_OFF_CTRL, 32'h09);
      repeat (2) @(posedge clk_i);
      chk("oe held", 0, sdo_oe_o);
      // Byte lane zero not selected: the write is acknowledged but ignored
      wb_sel_i <= 4'hE;
      wb(1'b1, `SSS_OFF_CTRL, 32'h0);
      wb_sel_i <= 4'hF;
      rd(`SSS_OFF_CTRL, 32'h09, 32'hFF, "ctrl sel");
      wb(1'b1, `SSS_OFF_CTRL, 32'h4B);
      rd(`SSS_OFF_STAT, 4, 32'h4, "cfg");
      $display("test modes done");
      results();
   end
endmodule : spi_slave_select_sleep_test
